// ===== tmr_pkg.sv
// Constants, field layouts and types of the 8-bit interval/PWM/capture timer.
// Assumes one system clock and a CPU register port at byte addresses.
// Overview of operation
// RULE1: Bits 7..5 pick prescaled system clock
// RULE2: Codes 101/110 external edges, 111 stops
// RULE3: Bits 4..3 pick interval, capture, PWM
// RULE4: Writing one to bit 2 clears counter
// RULE5: Clear bit drops back to zero itself
// RULE6: Bit 1 enables match/capture interrupt
// RULE7: Bit 0 enables overflow interrupt
// RULE8: Reset clears the whole control register
// RULE9: Overflow sets pending 0, cleared by service/software
// RULE10: Match/capture sets pending 1, pollable
// RULE11: Mask bit set: service clears pending 1
// RULE12: Mask bit clear: software clears pending 1
// RULE13: Interval match interrupts and restarts counter
// RULE14: Interval match inverts toggle output
// RULE15: PWM match leaves counter free running
// RULE16: PWM output high while data above count
// RULE17: PWM period is 256 counter ticks
// RULE18: Capture edge copies counter into data
// RULE19: Capture mode: overflow and capture interrupts
// RULE20: Software routes capture pin via port control
// RULE21: PWM mode allows both interrupts
// RULE22: Counter steps by one, wraps with overflow
package tmr_pkg;
	// Register addresses on the CPU register port
	localparam logic [7:0] TMR_CTRL_ADDR = 8'hE2;
	localparam logic [7:0] TMR_COUNT_ADDR = 8'hE4;
	localparam logic [7:0] TMR_DATA_ADDR = 8'hE5;
	localparam logic [7:0] TMR_PEND_ADDR = 8'hE6;
	// Control register reset value and field positions
	localparam logic [7:0] TMR_CTRL_RESET = 8'h00;
	localparam int TMR_CSEL_HI = 7;
	localparam int TMR_CSEL_LO = 5;
	localparam int TMR_MODE_HI = 4;
	localparam int TMR_MODE_LO = 3;
	localparam int TMR_CLR_BIT = 2;
	localparam int TMR_MIE_BIT = 1;
	localparam int TMR_OIE_BIT = 0;
	// Pending register bit positions
	localparam int TMR_PEND_OVF = 0;
	localparam int TMR_PEND_MATCH = 1;
	// Counter limits
	localparam logic [7:0] TMR_CNT_ZERO = 8'h00;
	localparam logic [7:0] TMR_CNT_MAX = 8'hFF;
	// Prescaler width and terminal masks per division
	localparam int TMR_PRE_W = 10;
	localparam logic [9:0] TMR_MASK_1024 = 10'h3FF;
	localparam logic [9:0] TMR_MASK_256 = 10'h0FF;
	localparam logic [9:0] TMR_MASK_64 = 10'h03F;
	localparam logic [9:0] TMR_MASK_8 = 10'h007;
	// Clock selection codes
	typedef enum logic [2:0] {
		TMR_CS_DIV1024 = 3'h0,
		TMR_CS_DIV256 = 3'h1,
		TMR_CS_DIV64 = 3'h2,
		TMR_CS_DIV8 = 3'h3,
		TMR_CS_DIV1 = 3'h4,
		TMR_CS_EXT_FALL = 3'h5,
		TMR_CS_EXT_RISE = 3'h6,
		TMR_CS_STOP = 3'h7
	} tmr_csel_e;
	// Operating modes
	typedef enum logic [1:0] {
		TMR_MODE_INTERVAL = 2'h0,
		TMR_MODE_CAP_RISE = 2'h1,
		TMR_MODE_CAP_FALL = 2'h2,
		TMR_MODE_PWM = 2'h3
	} tmr_mode_e;
endpackage

// ===== tmr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to CLOCK.
`timescale 1ns/100ps
module tmr_pin_sync
	import tmr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PIN,
	output logic RISE,
	output logic FALL
);
	logic s1_q; // First stage, read only by s2
	logic s2_q; // Second stage
	logic s3_q; // Third stage
	logic lvl_q; // Accepted pin level
	wire agree = (s2_q == s3_q); // Stages two and three agree
	wire change = agree && (s3_q != lvl_q); // New settled level

	// Shift chain
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= PIN;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accepted level and edge pulses
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			lvl_q <= 1'b0;
			RISE <= 1'b0;
			FALL <= 1'b0;
		end else begin
			lvl_q <= change ? s3_q : lvl_q;
			RISE <= change && s3_q;
			FALL <= change && !s3_q;
		end
	end
endmodule // tmr_pin_sync

// ===== tmr_timer.sv
// Top of the 8-bit timer: control register, prescaler, counter,
// compare, capture, toggle and PWM outputs, and pending bits.
// Assumes a CPU register port with one-cycle write strobe and
// registered read data; pins are asynchronous to CLOCK.
`timescale 1ns/100ps
module tmr_timer
	import tmr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	// CPU register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// Pins
	input wire logic EXTERNAL_COUNT_CLOCK,
	input wire logic CAPTURE_PIN,
	output logic INTERVAL_TOGGLE_OUT,
	output logic PULSE_WIDTH_OUT,
	// Interrupt controller side
	input wire logic INTERRUPT_MASK0,
	input wire logic SERVICE_OVERFLOW,
	input wire logic SERVICE_MATCH,
	output logic OVERFLOW_IRQ,
	output logic MATCH_CAPTURE_IRQ,
	output logic INTERRUPT_LEVEL_ZERO,
	output logic [1:0] INTERRUPT_PENDING
);
	// State registers
	logic [7:0] ctrl_q; // Control register
	logic [7:0] ctrl_d;
	logic [7:0] count_q; // Timer count
	logic [7:0] count_d;
	logic [7:0] data_q; // Reference data
	logic [7:0] data_d;
	logic [1:0] pend_q; // Pending bits
	logic [1:0] pend_d;
	logic [TMR_PRE_W-1:0] pre_q; // Free-running prescaler
	logic [TMR_PRE_W-1:0] pre_d;
	logic tog_q; // Interval toggle level
	logic tog_d;
	logic pwm_q; // PWM level
	logic pwm_d;
	logic [7:0] rdata_d; // Next read data

	// Synchronised pin edges
	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;

	// External count clock synchroniser
	tmr_pin_sync u_ext_sync (
		.CLOCK(CLOCK),
		.RST(RST),
		.PIN(EXTERNAL_COUNT_CLOCK),
		.RISE(ext_rise),
		.FALL(ext_fall)
	);

	// Capture pin synchroniser
	tmr_pin_sync u_cap_sync (
		.CLOCK(CLOCK),
		.RST(RST),
		.PIN(CAPTURE_PIN),
		.RISE(cap_rise),
		.FALL(cap_fall)
	);

	// Control field decode
	tmr_csel_e csel;
	tmr_mode_e mode;
	assign csel = tmr_csel_e'(ctrl_q[TMR_CSEL_HI:TMR_CSEL_LO]); // RULE1
	assign mode = tmr_mode_e'(ctrl_q[TMR_MODE_HI:TMR_MODE_LO]); // RULE3
	wire clr_pend = ctrl_q[TMR_CLR_BIT]; // Clear request held one cycle
	wire match_en = ctrl_q[TMR_MIE_BIT]; // RULE6
	wire ovf_en = ctrl_q[TMR_OIE_BIT]; // RULE7

	// Mode flags
	wire is_interval = (mode == TMR_MODE_INTERVAL);
	wire is_pwm = (mode == TMR_MODE_PWM);
	wire is_cap_rise = (mode == TMR_MODE_CAP_RISE);
	wire is_cap_fall = (mode == TMR_MODE_CAP_FALL);

	// Register port decode
	wire wr_ctrl = REG_WE && (REG_ADDR == TMR_CTRL_ADDR);
	wire wr_data = REG_WE && (REG_ADDR == TMR_DATA_ADDR);
	wire wr_pend = REG_WE && (REG_ADDR == TMR_PEND_ADDR);

	// Prescaler terminal counts
	wire pre_1024 = (pre_q & TMR_MASK_1024) == TMR_MASK_1024;
	wire pre_256 = (pre_q & TMR_MASK_256) == TMR_MASK_256;
	wire pre_64 = (pre_q & TMR_MASK_64) == TMR_MASK_64;
	wire pre_8 = (pre_q & TMR_MASK_8) == TMR_MASK_8;

	// Counter tick selection
	logic tick;
	always_comb begin
		case (csel)
			TMR_CS_DIV1024: tick = pre_1024; // RULE1
			TMR_CS_DIV256: tick = pre_256; // RULE1
			TMR_CS_DIV64: tick = pre_64; // RULE1
			TMR_CS_DIV8: tick = pre_8; // RULE1
			TMR_CS_DIV1: tick = 1'b1; // RULE1
			TMR_CS_EXT_FALL: tick = ext_fall; // RULE2
			TMR_CS_EXT_RISE: tick = ext_rise; // RULE2
			TMR_CS_STOP: tick = 1'b0; // RULE2
			default: tick = 1'b0;
		endcase
	end

	// Compare and wrap conditions
	wire equal = (count_q == data_q);
	wire at_max = (count_q == TMR_CNT_MAX);
	wire cmp_match = tick && equal && (is_interval || is_pwm);
	wire restart = cmp_match && is_interval; // RULE13
	wire wrap = tick && at_max && !restart; // RULE22
	wire cap_edge = (is_cap_rise && cap_rise) ||
		(is_cap_fall && cap_fall); // RULE18

	// Events that reach the pending bits
	wire ovf_event = wrap && ovf_en; // RULE9 RULE19 RULE21
	wire mc_event = (cmp_match || cap_edge) && match_en; // RULE10 RULE21

	// Hardware clears on service
	wire svc_ovf = SERVICE_OVERFLOW; // RULE9
	wire svc_mc = SERVICE_MATCH && INTERRUPT_MASK0; // RULE11

	// Software clears by writing zero
	wire sw_clr_ovf = wr_pend && !REG_WDATA[TMR_PEND_OVF]; // RULE9
	wire sw_clr_mc = wr_pend && !REG_WDATA[TMR_PEND_MATCH]; // RULE12

	// Control register next value
	always_comb begin
		ctrl_d = ctrl_q;
		// Clear bit falls on the same edge that clears the counter
		ctrl_d[TMR_CLR_BIT] = 1'b0; // RULE5
		if (wr_ctrl) begin
			ctrl_d = REG_WDATA; // RULE4
		end
	end

	// Prescaler runs on every clock
	assign pre_d = pre_q + 1'b1;

	// Counter next value
	always_comb begin
		count_d = count_q;
		if (clr_pend) begin
			// Written one clears the count
			count_d = TMR_CNT_ZERO; // RULE4
		end else if (restart) begin
			// Interval match restarts at zero
			count_d = TMR_CNT_ZERO; // RULE13
		end else if (tick) begin
			// Free count, wraps after maximum
			count_d = count_q + 8'h01; // RULE15 RULE17 RULE22
		end
	end

	// Reference data next value
	always_comb begin
		data_d = data_q;
		if (wr_data) begin
			data_d = REG_WDATA;
		end
		if (cap_edge) begin
			// Capture wins over a software write
			data_d = count_q; // RULE18
		end
	end

	// Pending bits: set wins over clear
	always_comb begin
		pend_d = pend_q;
		if (svc_ovf || sw_clr_ovf) begin
			pend_d[TMR_PEND_OVF] = 1'b0;
		end
		if (svc_mc || sw_clr_mc) begin
			pend_d[TMR_PEND_MATCH] = 1'b0;
		end
		if (ovf_event) begin
			pend_d[TMR_PEND_OVF] = 1'b1; // RULE9
		end
		if (mc_event) begin
			pend_d[TMR_PEND_MATCH] = 1'b1; // RULE10
		end
	end

	// Interval output toggles on each interval-mode match
	assign tog_d = restart ? !tog_q : tog_q; // RULE14

	// PWM output from data against count
	assign pwm_d = is_pwm ? (data_q > count_q) : 1'b0; // RULE16

	// Read data selection
	always_comb begin
		case (REG_ADDR)
			TMR_CTRL_ADDR: rdata_d = ctrl_q;
			TMR_COUNT_ADDR: rdata_d = count_q;
			TMR_DATA_ADDR: rdata_d = data_q;
			TMR_PEND_ADDR: rdata_d = {6'h00, pend_q};
			default: rdata_d = 8'h00;
		endcase
	end

	// Control register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q <= TMR_CTRL_RESET; // RULE8
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Prescaler
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_d;
		end
	end

	// Counter and reference data
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			count_q <= TMR_CNT_ZERO;
			data_q <= TMR_CNT_MAX;
		end else begin
			count_q <= count_d;
			data_q <= data_d;
		end
	end

	// Pending bits
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pend_q <= 2'h0;
		end else begin
			pend_q <= pend_d;
		end
	end

	// Output levels and read data
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			tog_q <= 1'b0;
			pwm_q <= 1'b0;
			REG_RDATA <= 8'h00;
		end else begin
			tog_q <= tog_d;
			pwm_q <= pwm_d;
			REG_RDATA <= rdata_d;
		end
	end

	// Pin and interrupt outputs
	assign INTERVAL_TOGGLE_OUT = tog_q;
	assign PULSE_WIDTH_OUT = pwm_q;
	assign OVERFLOW_IRQ = pend_q[TMR_PEND_OVF];
	assign MATCH_CAPTURE_IRQ = pend_q[TMR_PEND_MATCH];
	assign INTERRUPT_LEVEL_ZERO = |pend_q;
	assign INTERRUPT_PENDING = pend_q;
endmodule // tmr_timer

// ===== tmr_pin_model.sv
// Partner pins: external count clock pulse train and capture level.
// Assumes a one-cycle go request from the bench, idle level low.
`timescale 1ns/100ps
module tmr_pin_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] num,
	input wire logic cap_lvl,
	output logic ext_clk,
	output logic cap
);
	int left = 0; // Half pulses still to send, idle from the start
	int ph = 0; // Cycles within a half pulse
	// Capture pin routed straight to the timer as its capture source
	assign cap = cap_lvl;
	assign ext_clk = left[0]; // High on odd counts, low when idle
	// Slow pulse train, eight cycles a half period
	always @(posedge clk) begin
		if (go) begin
			left <= 2 * num;
			ph <= 0;
		end else if (left > 0) begin
			ph <= (ph + 1) % 8;
			if (ph == 7) left <= left - 1;
		end
	end
endmodule // tmr_pin_model

// ===== tmr_timer_checker.sv
// Port checker of the timer: register port, pins and pending bits.
// Assumes it is bound into tmr_timer; one clock, synchronous reset.
`timescale 1ns/100ps
module tmr_timer_checker
	import tmr_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic INTERVAL_TOGGLE_OUT,
	input wire logic PULSE_WIDTH_OUT,
	input wire logic INTERRUPT_MASK0,
	input wire logic SERVICE_OVERFLOW,
	input wire logic SERVICE_MATCH,
	input wire logic OVERFLOW_IRQ,
	input wire logic MATCH_CAPTURE_IRQ,
	input wire logic INTERRUPT_LEVEL_ZERO,
	input wire logic [1:0] INTERRUPT_PENDING
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	wire ctrl_wr = REG_WE && REG_ADDR == TMR_CTRL_ADDR; // Control write
	wire ctrl_rd = !REG_WE && REG_ADDR == TMR_CTRL_ADDR; // Control read
	wire pend_wr = REG_WE && REG_ADDR == TMR_PEND_ADDR; // Pending write
	chk_reset_quiet: assert property ($fell(RST) |->
		INTERRUPT_PENDING == 2'h0 && !INTERVAL_TOGGLE_OUT && !PULSE_WIDTH_OUT)
		else $error("outputs not idle after reset");
	chk_level_or: assert property (
		INTERRUPT_LEVEL_ZERO == |INTERRUPT_PENDING) else $error("level bad");
	chk_pend_map: assert property (
		INTERRUPT_PENDING == {MATCH_CAPTURE_IRQ, OVERFLOW_IRQ})
		else $error("pending map bad");
	chk_ovf_service: assert property (
		SERVICE_OVERFLOW |=> !OVERFLOW_IRQ) else $error("overflow kept");
	chk_match_service: assert property (
		SERVICE_MATCH && INTERRUPT_MASK0 |=> !MATCH_CAPTURE_IRQ)
		else $error("match kept");
	chk_match_hold: assert property (
		MATCH_CAPTURE_IRQ && !INTERRUPT_MASK0 && !pend_wr |=> MATCH_CAPTURE_IRQ)
		else $error("match lost");
	chk_pend_clear: assert property (
		pend_wr && REG_WDATA[1:0] == 2'h0 |=> INTERRUPT_PENDING == 2'h0)
		else $error("pending not cleared");
	chk_clear_self: assert property (
		ctrl_wr && REG_WDATA[TMR_CLR_BIT] ##1 ctrl_rd [*4]
		|-> !REG_RDATA[TMR_CLR_BIT]) else $error("clear bit stuck");
	chk_ctrl_store: assert property (
		ctrl_wr && !REG_WDATA[TMR_CLR_BIT] ##1 ctrl_rd [*2]
		|-> REG_RDATA == $past(REG_WDATA, 2)) else $error("control lost");
	chk_unmapped_zero: assert property (
		REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00) else $error("unmapped read");
	cover property (SERVICE_MATCH && INTERRUPT_MASK0 && MATCH_CAPTURE_IRQ);
	cover property ($rose(INTERVAL_TOGGLE_OUT));
	cover property ($rose(PULSE_WIDTH_OUT));
endmodule // tmr_timer_checker
bind tmr_timer tmr_timer_checker i_chk (.CLOCK(CLOCK), .RST(RST),
	.REG_ADDR(REG_ADDR), .REG_WE(REG_WE), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .INTERVAL_TOGGLE_OUT(INTERVAL_TOGGLE_OUT),
	.PULSE_WIDTH_OUT(PULSE_WIDTH_OUT), .INTERRUPT_MASK0(INTERRUPT_MASK0),
	.SERVICE_OVERFLOW(SERVICE_OVERFLOW), .SERVICE_MATCH(SERVICE_MATCH),
	.OVERFLOW_IRQ(OVERFLOW_IRQ), .MATCH_CAPTURE_IRQ(MATCH_CAPTURE_IRQ),
	.INTERRUPT_LEVEL_ZERO(INTERRUPT_LEVEL_ZERO),
	.INTERRUPT_PENDING(INTERRUPT_PENDING));

// ===== tb_top.sv
// Self-checking bench of the timer with its pin partner.
// Assumes tmr_pkg, tmr_timer, tmr_pin_model and the bound checker.
`timescale 1ns/100ps
module tb_top import tmr_pkg::*;;
	logic clk, rst, we, go, capl, m0, svo, svm, ext, cap, tog, pwm;
	logic [7:0] addr, wd, rdat, num, v;
	logic [1:0] pend;
	int n_fail = 0, n_tests = 0, n, d, tg, hi, rs;
	int dv[5] = '{1024, 256, 64, 8, 1}; // Division per clock code
	logic [31:0] r = 32'hD3A6; // Random state
	tmr_timer i_dut (.CLOCK(clk), .RST(rst), .REG_ADDR(addr), .REG_WE(we),
		.REG_WDATA(wd), .REG_RDATA(rdat), .EXTERNAL_COUNT_CLOCK(ext),
		.CAPTURE_PIN(cap), .INTERVAL_TOGGLE_OUT(tog), .PULSE_WIDTH_OUT(pwm),
		.INTERRUPT_MASK0(m0), .SERVICE_OVERFLOW(svo), .SERVICE_MATCH(svm),
		.OVERFLOW_IRQ(), .MATCH_CAPTURE_IRQ(), .INTERRUPT_LEVEL_ZERO(),
		.INTERRUPT_PENDING(pend));
	tmr_pin_model i_pins (.clk(clk), .go(go), .num(num), .cap_lvl(capl),
		.ext_clk(ext), .cap(cap));
	// Free-running clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cyc(int k);
		we = 1'h0;
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Write strobe stays up until the next operation lowers it
	task automatic wr(logic [7:0] a, logic [7:0] x);
		addr = a;
		wd = x;
		we = 1'h1;
		@(posedge clk) #1;
	endtask
	task automatic rd(logic [7:0] a);
		addr = a;
		cyc(2);
		v = rdat;
	endtask
	task automatic cmp(string nm, int e, logic [9:0] g, int t);
		logic ok;
		n_tests++;
		ok = (g + t >= e) && (g <= e + t);
		if (ok !== 1'h1) begin
			n_fail++;
			$display("unexpected %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// Count toggles, PWM high cycles and PWM rises
	task automatic watch(int k);
		logic pt, pp;
		{tg, hi, rs} = '0;
		we = 1'h0;
		pt = tog;
		pp = pwm;
		repeat (k) begin
			@(posedge clk) #1;
			tg += (tog !== pt);
			hi += (pwm === 1'h1);
			rs += (pwm === 1'h1 && pp === 1'h0);
			pt = tog;
			pp = pwm;
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		results();
	end
	initial begin
		{we, go, capl, m0, svo, svm, addr, wd, num} = '0;
		rst = 1'h1;
		repeat (12) @(posedge clk);
		#1 rst = 1'h0;
		rd(TMR_CTRL_ADDR); cmp("ctrl", 0, v, 0);
		rd(TMR_DATA_ADDR); cmp("data", 255, v, 0);
		rd(8'h00); cmp("unmapped", 0, v, 0);
		wr(TMR_CTRL_ADDR, 8'hFB);
		rd(TMR_CTRL_ADDR); cmp("ctrl", 251, v, 0);
		$display("test reset done");
		for (int k = 0; k < 5; k++) begin
			wr(TMR_CTRL_ADDR, {k[2:0], 5'h04});
			cyc(dv[k] * 8);
			wr(TMR_CTRL_ADDR, 8'hE0);
			rd(TMR_COUNT_ADDR); cmp("count", 8, v, 2);
		end
		rd(TMR_CTRL_ADDR); cmp("ctrl", 224, v, 0);
		$display("test prescaler done");
		for (int c = 5; c < 7; c++) begin
			r = nx(r);
			n = 1 + r[3:0] % 15;
			num = n[7:0];
			wr(TMR_CTRL_ADDR, {c[2:0], 5'h04});
			go = 1'h1;
			cyc(1);
			go = 1'h0;
			cyc(16 * n + 20);
			wr(TMR_CTRL_ADDR, 8'hE0);
			rd(TMR_COUNT_ADDR); cmp("ext count", n, v, 0);
		end
		cyc(50);
		rd(TMR_COUNT_ADDR); cmp("held count", n, v, 0);
		$display("test external done");
		wr(TMR_CTRL_ADDR, 8'hF2);
		wr(TMR_DATA_ADDR, 8'h11);
		capl = 1'h1;
		cyc(10);
		rd(TMR_DATA_ADDR); cmp("data", 17, v, 0);
		capl = 1'h0;
		cyc(10);
		rd(TMR_DATA_ADDR); cmp("capture", n, v, 0);
		rd(TMR_PEND_ADDR); cmp("pend", 2, v, 0);
		svm = 1'h1;
		cyc(1);
		svm = 1'h0;
		rd(TMR_PEND_ADDR); cmp("pend", 2, v, 0);
		m0 = 1'h1;
		svm = 1'h1;
		cyc(1);
		{svm, m0} = '0;
		rd(TMR_PEND_ADDR); cmp("pend", 0, v, 0);
		wr(TMR_CTRL_ADDR, 8'hEA);
		wr(TMR_DATA_ADDR, 8'h11);
		capl = 1'h1;
		cyc(10);
		rd(TMR_DATA_ADDR); cmp("capture", n, v, 0);
		wr(TMR_PEND_ADDR, 8'h00);
		rd(TMR_PEND_ADDR); cmp("pend", 0, v, 0);
		$display("test capture done");
		wr(TMR_DATA_ADDR, 8'h03);
		wr(TMR_CTRL_ADDR, 8'h86);
		watch(80); cmp("toggles", 20, tg, 1);
		cmp("pwm high", 0, hi, 0);
		wr(TMR_CTRL_ADDR, 8'hE2);
		rd(TMR_PEND_ADDR); cmp("pend", 2, v, 0);
		wr(TMR_PEND_ADDR, 8'h00);
		wr(TMR_CTRL_ADDR, 8'h84);
		watch(40);
		wr(TMR_CTRL_ADDR, 8'hE0);
		rd(TMR_PEND_ADDR); cmp("pend", 0, v, 0);
		$display("test interval done");
		r = nx(r);
		d = 1 + r[7:0] % 254;
		wr(TMR_DATA_ADDR, d[7:0]);
		wr(TMR_CTRL_ADDR, 8'h9D);
		watch(512); cmp("pwm high", 2 * d, hi, 2);
		cmp("pwm periods", 2, rs, 1);
		wr(TMR_CTRL_ADDR, 8'hF9);
		rd(TMR_PEND_ADDR); cmp("pend", 1, v, 0);
		svo = 1'h1;
		cyc(1);
		svo = 1'h0;
		rd(TMR_PEND_ADDR); cmp("pend", 0, v, 0);
		$display("test pwm done");
		results();
	end
endmodule // tb_top
